// >>> inc/nsc_pkg.sv
package nsc_pkg;

    // ==================================================
    // register map
    localparam logic [7:0] NSC_REG_PROG_ADDR = 8'h0D;
    localparam logic [7:0] NSC_REG_PROG_WORD = 8'h0E;
    localparam logic [7:0] NSC_REG_STARTUP = 8'h0F;

    // ==================================================
    // reset values
    localparam logic [15:0] NSC_PROG_WORD_RST = 16'h0000;
    localparam logic [5:0] NSC_PROG_ADDR_RST = 6'h00;
    localparam logic [15:0] NSC_STARTUP_RST = 16'h0037;

    // ==================================================
    // startup control field positions
    localparam int NSC_LOCK_LSB = 12;
    localparam int NSC_LOCK_W = 4;
    localparam logic [3:0] NSC_UNLOCK_KEY = 4'h5;
    localparam int NSC_AUTO_DIV_BIT = 8;
    localparam int NSC_BYP_CAL_BIT = 7;
    localparam int NSC_BYP_CFG_BIT = 6;
    localparam int NSC_CAL_MUTE_BIT = 5;
    localparam int NSC_SHIFT_LSB = 3;
    localparam int NSC_SCL_FILT_BIT = 2;
    localparam int NSC_SDA_FILT_BIT = 1;
    localparam int NSC_ACAL_BIT = 0;
    localparam int NSC_PROG_ADDR_W = 6;

    // ==================================================
    // timing
    localparam int NSC_CLK_MHZ = 200;
    localparam int NSC_FILT_TIME_NS = 50;
    localparam int NSC_FILT_CYC =
        (NSC_FILT_TIME_NS * NSC_CLK_MHZ + 999) / 1000;

    // ==================================================
    // startup sequencer states
    typedef enum logic [2:0] {
        NSC_ST_BOOT,
        NSC_ST_IDLE,
        NSC_ST_CONFIG,
        NSC_ST_CAL1,
        NSC_ST_CAL2
    } nsc_state_t;

endpackage

// >>> rtl/nsc_pin_filter.sv
`timescale 1ns/1ps

module nsc_pin_filter #(
    parameter int STABLE_CYC = 10
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pin side
    input wire logic pin_in,
    input wire logic filt_en,
    // filtered level
    output logic pin_out
);

    // ==================================================
    // synchroniser
    logic s1_q, s2_q, s3_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ==================================================
    // spike suppression
    logic out_q, out_d;
    logic [7:0] cnt_q, cnt_d;
    logic agree;

    assign agree = (s2_q == s3_q);

    always_comb begin
        out_d = out_q;
        cnt_d = 8'h00;
        if (!filt_en) begin
            if (agree) begin
                out_d = s3_q;
            end
        end else if (agree && (s3_q != out_q)) begin
            // level must hold for the whole window before it passes
            if (cnt_q >= 8'(STABLE_CYC - 1)) begin
                out_d = s3_q;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 1'b1;
            cnt_q <= 8'h00;
        end else begin
            out_q <= out_d;
            cnt_q <= cnt_d;
        end
    end

    assign pin_out = out_q;

endmodule

// >>> rtl/nsc_nvm_startup_ctrl.sv
`timescale 1ns/1ps

// Operation
// (R01) data write programs word at set address
// (R02) each further write advances address by one
// (R03) address write sets start of programming
// (R04) lock key 5h enables commit and programming
// (R05) locked data writes leave memory unchanged
// (R06) auto bit lets sequencer drive feedback divider
// (R07) two calibration rounds unless bypass set
// (R08) config bypass clears at power-on, honoured later
// (R09) mute bit resets 1, mutes during calibration
// (R10) calibration reference divided by two^field
// (R11) bit 2 enables clock-line glitch filter
// (R12) bit 1 enables data-line glitch filter
// (R13) bit 0 enables automatic calibration runs
module nsc_nvm_startup_ctrl
    import nsc_pkg::*;
#(
    parameter int NDIV_W = 15,
    parameter int PSFB_W = 2,
    parameter int FILT_CYC = NSC_FILT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port from the serial host interface
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rd_valid,
    // nonvolatile memory programming
    output logic nvm_prog_stb,
    output logic [5:0] nvm_prog_addr,
    output logic [15:0] nvm_prog_data,
    output logic nvm_commit_enable,
    // startup events
    input wire logic soft_reset_req,
    input wire logic nvm_reload_done,
    input wire logic config_done,
    input wire logic cal_round_done,
    // startup status
    output logic config_run,
    output logic cal_round1_run,
    output logic cal_round2_run,
    output logic cal_active,
    output logic outputs_mute,
    output logic [1:0] cal_ref_div_log2,
    output logic [3:0] cal_ref_div_ratio,
    // feedback divider
    input wire logic [NDIV_W-1:0] sw_fb_ndiv,
    input wire logic [PSFB_W-1:0] sw_fb_psfb,
    input wire logic [NDIV_W-1:0] seq_fb_ndiv,
    input wire logic [PSFB_W-1:0] seq_fb_psfb,
    output logic [NDIV_W-1:0] fb_ndiv,
    output logic [PSFB_W-1:0] fb_psfb,
    output logic fb_from_seq,
    // serial pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic scl_filtered,
    output logic sda_filtered
);

    // ==================================================
    // register file
    logic [15:0] startup_q, startup_d;
    logic [15:0] word_q, word_d;
    logic [5:0] paddr_q, paddr_d;
    logic prog_stb_q, prog_stb_d;
    logic [5:0] prog_addr_q, prog_addr_d;
    logic [15:0] prog_data_q, prog_data_d;
    logic [15:0] rdata_q, rdata_d;
    logic rd_valid_q, rd_valid_d;
    logic unlocked;

    // unlock key check
    // (R04) key compare
    assign unlocked =
        startup_q[NSC_LOCK_LSB +: NSC_LOCK_W] == NSC_UNLOCK_KEY;

    always_comb begin
        startup_d = startup_q;
        word_d = word_q;
        paddr_d = paddr_q;
        prog_stb_d = 1'b0;
        prog_addr_d = prog_addr_q;
        prog_data_d = prog_data_q;
        rd_valid_d = reg_rd_en;
        rdata_d = rdata_q;
        if (reg_wr_en) begin
            case (reg_addr)
                NSC_REG_PROG_ADDR: begin
                    // (R03) start location
                    paddr_d = reg_wdata[NSC_PROG_ADDR_W-1:0];
                end
                NSC_REG_PROG_WORD: begin
                    word_d = reg_wdata;
                    // (R05) locked, no program
                    if (unlocked) begin
                        // (R01) program word
                        prog_stb_d = 1'b1;
                        prog_addr_d = paddr_q;
                        prog_data_d = reg_wdata;
                        // (R02) advance address
                        paddr_d = paddr_q + 6'h01;
                    end
                end
                NSC_REG_STARTUP: begin
                    startup_d = reg_wdata;
                end
                default: begin
                    startup_d = startup_q;
                end
            endcase
        end
        if (reg_rd_en) begin
            case (reg_addr)
                NSC_REG_PROG_ADDR: rdata_d = {10'h000, paddr_q};
                NSC_REG_PROG_WORD: rdata_d = word_q;
                NSC_REG_STARTUP: rdata_d = startup_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // power-on reset clears config bypass; soft reset does not touch it
    // (R08) power-on clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            startup_q <= NSC_STARTUP_RST;
            word_q <= NSC_PROG_WORD_RST;
            paddr_q <= NSC_PROG_ADDR_RST;
            prog_stb_q <= 1'b0;
            prog_addr_q <= NSC_PROG_ADDR_RST;
            prog_data_q <= NSC_PROG_WORD_RST;
            rdata_q <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            startup_q <= startup_d;
            word_q <= word_d;
            paddr_q <= paddr_d;
            prog_stb_q <= prog_stb_d;
            prog_addr_q <= prog_addr_d;
            prog_data_q <= prog_data_d;
            rdata_q <= rdata_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;
    assign nvm_prog_stb = prog_stb_q;
    assign nvm_prog_addr = prog_addr_q;
    assign nvm_prog_data = prog_data_q;
    // (R04) commit gate
    assign nvm_commit_enable = unlocked;

    // ==================================================
    // startup sequencer
    nsc_state_t state_q, state_d;
    logic byp_cal, byp_cfg, acal_en;
    nsc_state_t cal_entry;

    assign byp_cal = startup_q[NSC_BYP_CAL_BIT];
    assign byp_cfg = startup_q[NSC_BYP_CFG_BIT];
    assign acal_en = startup_q[NSC_ACAL_BIT];

    // (R13) auto calibration gate
    // (R07) bypass skips both rounds
    assign cal_entry = (acal_en && !byp_cal) ? NSC_ST_CAL1 : NSC_ST_IDLE;

    always_comb begin
        state_d = state_q;
        case (state_q)
            NSC_ST_BOOT: begin
                // power-up always configures; bypass is clear here
                state_d = NSC_ST_CONFIG;
            end
            NSC_ST_IDLE: begin
                if (nvm_reload_done) begin
                    state_d = cal_entry;
                end
            end
            NSC_ST_CONFIG: begin
                if (config_done) begin
                    state_d = cal_entry;
                end
            end
            NSC_ST_CAL1: begin
                // (R07) first then second
                if (cal_round_done) begin
                    state_d = NSC_ST_CAL2;
                end
            end
            NSC_ST_CAL2: begin
                if (cal_round_done) begin
                    state_d = NSC_ST_IDLE;
                end
            end
            default: begin
                state_d = NSC_ST_IDLE;
            end
        endcase
        // soft reset restarts the sequence from any state except NSC_ST_BOOT
        if (soft_reset_req && state_q != NSC_ST_BOOT) begin
            // (R08) skip configuration
            state_d = byp_cfg ? cal_entry : NSC_ST_CONFIG;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= NSC_ST_BOOT;
        end else begin
            state_q <= state_d;
        end
    end

    assign config_run = (state_q == NSC_ST_CONFIG);
    assign cal_round1_run = (state_q == NSC_ST_CAL1);
    assign cal_round2_run = (state_q == NSC_ST_CAL2);
    assign cal_active = cal_round1_run | cal_round2_run;
    // (R09) mute while calibrating
    assign outputs_mute = cal_active & startup_q[NSC_CAL_MUTE_BIT];
    // (R10) reference divide
    assign cal_ref_div_log2 = startup_q[NSC_SHIFT_LSB +: 2];
    assign cal_ref_div_ratio = 4'h1 << cal_ref_div_log2;

    // ==================================================
    // feedback divider selection
    logic [NDIV_W-1:0] ndiv_q, ndiv_d;
    logic [PSFB_W-1:0] psfb_q, psfb_d;
    logic from_seq_q, from_seq_d;

    always_comb begin
        // (R06) sequencer owns divider
        from_seq_d = startup_q[NSC_AUTO_DIV_BIT] & cal_active;
        ndiv_d = from_seq_d ? seq_fb_ndiv : sw_fb_ndiv;
        psfb_d = from_seq_d ? seq_fb_psfb : sw_fb_psfb;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ndiv_q <= '0;
            psfb_q <= '0;
            from_seq_q <= 1'b0;
        end else begin
            ndiv_q <= ndiv_d;
            psfb_q <= psfb_d;
            from_seq_q <= from_seq_d;
        end
    end

    assign fb_ndiv = ndiv_q;
    assign fb_psfb = psfb_q;
    assign fb_from_seq = from_seq_q;

    // ==================================================
    // serial pin glitch filters
    // (R11) clock-line filter
    nsc_pin_filter #(
        .STABLE_CYC(FILT_CYC)
    ) u_scl_filt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(scl_pin),
        .filt_en(startup_q[NSC_SCL_FILT_BIT]),
        .pin_out(scl_filtered)
    );

    // (R12) data-line filter
    nsc_pin_filter #(
        .STABLE_CYC(FILT_CYC)
    ) u_sda_filt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(sda_pin),
        .filt_en(startup_q[NSC_SDA_FILT_BIT]),
        .pin_out(sda_filtered)
    );

endmodule

// >>> tb/nsc_ctrl_assertions.sv
`timescale 1ns/1ps

// =======
// checker on the top ports
module nsc_ctrl_checker
    import nsc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    // programming
    input wire logic nvm_prog_stb,
    input wire logic [5:0] nvm_prog_addr,
    input wire logic [15:0] nvm_prog_data,
    input wire logic nvm_commit_enable,
    // startup
    input wire logic cal_round1_run,
    input wire logic cal_round2_run,
    input wire logic cal_active,
    input wire logic outputs_mute,
    input wire logic [1:0] cal_ref_div_log2,
    input wire logic [3:0] cal_ref_div_ratio,
    input wire logic fb_from_seq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic dw;
    assign dw = reg_wr_en && reg_addr == NSC_REG_PROG_WORD;

    a_prog_on_write: assert property (
        dw && nvm_commit_enable |=>
        nvm_prog_stb && nvm_prog_data == $past(reg_wdata))
        else $error("no program after data write");
    a_prog_needs_key: assert property (
        nvm_prog_stb |-> $past(dw && nvm_commit_enable))
        else $error("program without key or write");
    a_addr_advance: assert property (
        dw && nvm_commit_enable && nvm_prog_stb |=>
        nvm_prog_addr == $past(nvm_prog_addr) + 6'h01)
        else $error("address did not advance");
    a_addr_start: assert property (
        reg_wr_en && reg_addr == NSC_REG_PROG_ADDR
        ##1 dw && nvm_commit_enable |=>
        nvm_prog_addr == $past(reg_wdata[5:0], 2))
        else $error("start address not used");
    a_ratio_pow: assert property (
        $onehot(cal_ref_div_ratio)
        && cal_ref_div_ratio[cal_ref_div_log2])
        else $error("divide ratio wrong");
    a_mute_in_cal: assert property (
        outputs_mute |-> cal_active)
        else $error("mute outside calibration");
    a_round_order: assert property (
        $rose(cal_round2_run) |-> $past(cal_round1_run))
        else $error("second round without first");
    a_round_excl: assert property (
        cal_active == (cal_round1_run || cal_round2_run)
        && !(cal_round1_run && cal_round2_run))
        else $error("round flags inconsistent");
    a_fb_in_cal: assert property (
        fb_from_seq |-> $past(cal_active))
        else $error("sequencer divider outside calibration");

    c_prog_burst: cover property (nvm_prog_stb ##1 nvm_prog_stb);
    c_round2: cover property (cal_round2_run && outputs_mute);
    c_fb_seq: cover property (fb_from_seq);
endmodule

bind nsc_nvm_startup_ctrl nsc_ctrl_checker u_chk (
    .clk_sys, .rst_n, .reg_wr_en, .reg_addr, .reg_wdata,
    .nvm_prog_stb, .nvm_prog_addr, .nvm_prog_data, .nvm_commit_enable,
    .cal_round1_run, .cal_round2_run, .cal_active, .outputs_mute,
    .cal_ref_div_log2, .cal_ref_div_ratio, .fb_from_seq
);

// >>> tb/tb.sv
`timescale 1ns/1ps

module tb;
    import nsc_pkg::*;
    logic clk_sys = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0;
    logic soft_reset_req = 0, nvm_reload_done = 0;
    logic config_done = 0, cal_round_done = 0;
    logic scl_pin = 1, sda_pin = 1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, nvm_prog_data;
    logic reg_rd_valid, nvm_prog_stb, nvm_commit_enable, fb_from_seq;
    logic config_run, cal_round1_run, cal_round2_run, cal_active;
    logic outputs_mute, scl_filtered, sda_filtered;
    logic [5:0] nvm_prog_addr;
    logic [1:0] cal_ref_div_log2, fb_psfb;
    logic [1:0] sw_fb_psfb = 2'h1, seq_fb_psfb = 2'h2;
    logic [3:0] cal_ref_div_ratio;
    logic [14:0] sw_fb_ndiv = 15'h1234, seq_fb_ndiv = 15'h0ABC, fb_ndiv;
    int miscompares = 0, comparisons = 0;

    always #2.5 clk_sys = ~clk_sys;

    // short filter window keeps glitch tests brief
    nsc_nvm_startup_ctrl #(.FILT_CYC(3)) dut_u (
        .clk_sys, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rd_valid, .nvm_prog_stb, .nvm_prog_addr,
        .nvm_prog_data, .nvm_commit_enable, .soft_reset_req,
        .nvm_reload_done, .config_done, .cal_round_done, .config_run,
        .cal_round1_run, .cal_round2_run, .cal_active, .outputs_mute,
        .cal_ref_div_log2, .cal_ref_div_ratio, .sw_fb_ndiv, .sw_fb_psfb,
        .seq_fb_ndiv, .seq_fb_psfb, .fb_ndiv, .fb_psfb, .fb_from_seq,
        .scl_pin, .sda_pin, .scl_filtered, .sda_filtered
    );

    // =======
    // helpers
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] e, string n);
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        #1;
        chk("valid", 16'h0001, {15'h0000, reg_rd_valid});
        chk(n, e, reg_rdata);
    endtask
    task automatic ev(int k);
        @(posedge clk_sys);
        case (k)
            0: config_done <= 1'b1;
            1: cal_round_done <= 1'b1;
            2: nvm_reload_done <= 1'b1;
            default: soft_reset_req <= 1'b1;
        endcase
        @(posedge clk_sys);
        {config_done, cal_round_done, nvm_reload_done} <= 3'h0;
        soft_reset_req <= 1'b0;
        #1;
    endtask
    // order: config, round1, round2, active, mute
    task automatic st(logic [4:0] e);
        chk("state", {11'h000, e}, {11'h000, config_run, cal_round1_run,
            cal_round2_run, cal_active, outputs_mute});
    endtask
    task automatic gl(logic [1:0] e, int n);
        logic [1:0] lo;
        lo = 2'h0;
        @(posedge clk_sys);
        {scl_pin, sda_pin} <= 2'h0;
        repeat (n) @(posedge clk_sys);
        {scl_pin, sda_pin} <= 2'h3;
        repeat (12) begin
            @(posedge clk_sys);
            #1;
            lo = lo | ~{scl_filtered, sda_filtered};
        end
        chk("glitch", {14'h0000, e}, {14'h0000, lo});
    endtask

    // =======
    // scenarios
    task automatic t_reset();
        chk("div", 16'h0004, {12'h000, cal_ref_div_ratio});
        rd(NSC_REG_STARTUP, 16'h0037, "startup");
        rd(NSC_REG_PROG_WORD, 16'h0000, "word");
        rd(NSC_REG_PROG_ADDR, 16'h0000, "addr");
        wr(8'h20, 16'hFFFF);
        rd(8'h20, 16'h0000, "unmapped");
        $display("t_reset done");
    endtask
    task automatic t_prog();
        wr(NSC_REG_STARTUP, 16'h5037);
        chk("commit", 16'h0001, {15'h0000, nvm_commit_enable});
        // address then two data words, back to back
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= NSC_REG_PROG_ADDR;
        reg_wdata <= 16'h0003;
        @(posedge clk_sys);
        reg_addr <= NSC_REG_PROG_WORD;
        reg_wdata <= 16'hA55A;
        @(posedge clk_sys);
        reg_wdata <= 16'h0FF0;
        #1;
        chk("stb", 16'h0001, {15'h0000, nvm_prog_stb});
        chk("paddr", 16'h0003, {10'h000, nvm_prog_addr});
        chk("pdata", 16'hA55A, nvm_prog_data);
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        #1;
        chk("paddr", 16'h0004, {10'h000, nvm_prog_addr});
        chk("pdata", 16'h0FF0, nvm_prog_data);
        rd(NSC_REG_PROG_ADDR, 16'h0005, "addr");
        wr(NSC_REG_STARTUP, 16'h6037);
        chk("commit", 16'h0000, {15'h0000, nvm_commit_enable});
        wr(NSC_REG_PROG_WORD, 16'hBEEF);
        chk("stb", 16'h0000, {15'h0000, nvm_prog_stb});
        chk("pdata", 16'h0FF0, nvm_prog_data);
        rd(NSC_REG_PROG_ADDR, 16'h0005, "addr");
        $display("t_prog done");
    endtask
    task automatic t_seq();
        st(5'h10);
        ev(0);
        st(5'h0B);
        ev(1);
        st(5'h07);
        ev(1);
        st(5'h00);
        wr(NSC_REG_STARTUP, 16'h5117);
        ev(2);
        st(5'h0A);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("fbsel", 16'h0001, {15'h0000, fb_from_seq});
        chk("ndiv", 16'h0ABC, {1'b0, fb_ndiv});
        chk("psfb", 16'h0002, {14'h0000, fb_psfb});
        ev(1);
        ev(1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("ndiv", 16'h1234, {1'b0, fb_ndiv});
        chk("psfb", 16'h0001, {14'h0000, fb_psfb});
        wr(NSC_REG_STARTUP, 16'h5197);
        ev(2);
        st(5'h00);
        wr(NSC_REG_STARTUP, 16'h5116);
        ev(2);
        st(5'h00);
        wr(NSC_REG_STARTUP, 16'h5157);
        ev(3);
        st(5'h0A);
        ev(1);
        ev(1);
        wr(NSC_REG_STARTUP, 16'h5117);
        ev(3);
        st(5'h10);
        $display("t_seq done");
    endtask
    // power-on reset mid-run must clear the config bypass again
    task automatic t_por();
        wr(NSC_REG_STARTUP, 16'h5157);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        st(5'h00);
        @(posedge clk_sys);
        #1;
        st(5'h10);
        chk("commit", 16'h0000, {15'h0000, nvm_commit_enable});
        rd(NSC_REG_STARTUP, 16'h0037, "startup");
        $display("t_por done");
    endtask
    task automatic t_div();
        for (int k = 0; k < 4; k++) begin
            wr(NSC_REG_STARTUP, {11'h000, k[1:0], 3'h0});
            chk("ratio", 16'h0001 << k, {12'h000, cal_ref_div_ratio});
            chk("log2", {14'h0000, k[1:0]}, {14'h0000, cal_ref_div_log2});
        end
        $display("t_div done");
    endtask
    task automatic t_filt();
        wr(NSC_REG_STARTUP, 16'h0037);
        gl(2'h0, 2);
        wr(NSC_REG_STARTUP, 16'h0033);
        gl(2'h2, 2);
        wr(NSC_REG_STARTUP, 16'h0035);
        gl(2'h1, 2);
        // a level held past the window must still pass the filter
        wr(NSC_REG_STARTUP, 16'h0037);
        gl(2'h3, 6);
        $display("t_filt done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_prog();
        t_seq();
        t_por();
        t_div();
        t_filt();
        results();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk_sys);
        miscompares++;
        results();
    end
endmodule
